// [smc_chk.sv]
// port assertions for the supply monitor control block
`timescale 1ns/10ps
module smc_chk #(
   parameter int TICK    = 8,
   parameter int HOLDOFF = 3
) (
   input wire logic               clock,
   input wire logic               nrst,
   input wire smc_pkg::smc_bus_s  bus,
   input wire logic               digital_supply_ok,
   input wire logic               irq_enable,
   input wire logic [7:0]         rdata,
   input wire logic               irq,
   input wire logic               watchdog_enable_clr,
   input wire smc_pkg::smc_trip_e digital_trip,
   input wire smc_pkg::smc_trip_e analog_trip,
   input wire logic               monitor_enable
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic hit;
   assign hit = bus.addr == smc_pkg::SMC_CTRL_ADDR;
   // sixteen low cycles outlast sync plus filter with margin
   sequence d_low_s;
      !digital_supply_ok && monitor_enable && irq_enable;
   endsequence
   sequence d_long_s;
      d_low_s [*8] ##1 d_low_s [*8];
   endsequence
   en_write_a: assert property (
      bus.wr && hit |=> monitor_enable == $past(bus.wdata[0]))
      else $error("enable bit not taken");
   dtrip_write_a: assert property (
      bus.wr && hit |=> digital_trip == $past(bus.wdata[4:3]))
      else $error("digital trip not taken");
   atrip_write_a: assert property (
      bus.wr && hit |=> analog_trip == $past(bus.wdata[2:1]))
      else $error("analog trip not taken");
   fields_read_a: assert property (
      bus.rd && !bus.wr && hit |=>
      rdata[4:0] == {digital_trip, analog_trip, monitor_enable})
      else $error("read fields differ from outputs");
   irq_gate_a: assert property (!irq_enable |=> !irq)
      else $error("interrupt without enable");
   wdt_follow_a: assert property (watchdog_enable_clr == irq)
      else $error("watchdog clear differs from interrupt");
   low_raise_a: assert property (d_long_s |-> irq)
      else $error("low supply raised no interrupt");
   low_keep_a: assert property (
      d_long_s ##0 (bus.wr && hit && !bus.wdata[5]) ##1 d_low_s |=> irq)
      else $error("flag cleared while supply low");
endmodule

// [smc_filter.sv]
// synchroniser and glitch filter for one comparator output
`timescale 1ns/10ps
module smc_filter #(
   parameter int FILT = smc_pkg::GLITCH_CYCLES
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic raw,
   output logic      clean
);
   logic       s1_r;
   logic       s2_r;
   logic [7:0] cnt_r;

   // two stages before any logic sees the comparator
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end

   // a level must hold FILT cycles before it is accepted
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_r <= 8'h00;
         clean <= 1'b1;
      end else if (s2_r == clean) begin
         cnt_r <= 8'h00;
      end else if (cnt_r == 8'(FILT - 1)) begin
         cnt_r <= 8'h00;
         clean <= s2_r;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule

// [smc_pkg.sv]
// shared constants and types for the supply monitor control block
package smc_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] SMC_CTRL_ADDR   = 8'hDF;
   localparam logic [7:0] SMC_CTRL_RESET  = 8'hDE;
   localparam int         SMC_BIT_DOK     = 7;
   localparam int         SMC_BIT_AOK     = 6;
   localparam int         SMC_BIT_FLAG    = 5;
   localparam int         SMC_BIT_DSEL_HI = 4;
   localparam int         SMC_BIT_DSEL_LO = 3;
   localparam int         SMC_BIT_ASEL_HI = 2;
   localparam int         SMC_BIT_ASEL_LO = 1;
   localparam int         SMC_BIT_EN      = 0;

   // -----------------------------------------------------------------
   // trip codes: 00 4.63 V, 01 3.08 V, 10 2.93 V, 11 2.63 V
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SMC_TRIP_4V63 = 2'h0,
      SMC_TRIP_3V08 = 2'h1,
      SMC_TRIP_2V93 = 2'h2,
      SMC_TRIP_2V63 = 2'h3
   } smc_trip_e;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ         = 40_000_000;
   localparam int HOLDOFF_MS     = 250;
   localparam int TICK_US        = 1000;
   localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
   localparam int HOLDOFF_TICKS  = HOLDOFF_MS * 1000 / TICK_US;
   localparam int GLITCH_CYCLES  = 8;

   // -----------------------------------------------------------------
   // special function register bus carrier
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smc_bus_s;

   typedef enum logic [2:0] {
      SMC_ST_OK      = 3'b001,
      SMC_ST_LOW     = 3'b010,
      SMC_ST_HOLDOFF = 3'b100
   } smc_state_e;
endpackage

// [smc_supply_model.sv]
// comparator model: supply in millivolts against the selected trip level
`timescale 1ns/10ps
module smc_supply_model (
   input  wire smc_pkg::smc_trip_e digital_trip,
   input  wire smc_pkg::smc_trip_e analog_trip,
   input  wire logic [12:0]        dv_mv,
   input  wire logic [12:0]        av_mv,
   output logic                    digital_supply_ok,
   output logic                    analog_supply_ok
);
   // thresholds 4630, 3080, 2930, 2630 mV
   function automatic logic [12:0] trip_mv(logic [1:0] c);
      return c[1] ? (c[0] ? 13'hA46 : 13'hB72) : (c[0] ? 13'hC08 : 13'h1216);
   endfunction
   assign digital_supply_ok = dv_mv > trip_mv(digital_trip);
   assign analog_supply_ok  = av_mv > trip_mv(analog_trip);
endmodule

// [smc_top.sv]
// supply monitor control register, low-supply flag and hold-off timer
`timescale 1ns/10ps
// How it works
// - bit 0 written 1 turns monitoring on, written 0 turns it off.
// - bit 7 reads the live filtered digital-supply comparator.
// - bit 6 reads the live filtered analogue-supply comparator.
// - the low-supply flag in bit 5 sets while either comparator is low.
// - once both are high a 250 ms hold-off runs and then clears the flag.
// - software may write the flag but cannot clear it while a supply is low.
// - the flag requests an interrupt only when its enable bit is set.
// - bits 4:3 pick the digital trip level 4.63/3.08/2.93/2.63 V.
// - bits 2:1 pick the analogue trip level with the same codes.
// - after reset the register reads DEH with monitoring off.
// - short glitches on the comparators are filtered out.
// - the monitor interrupt clears the watchdog enable bit.
module smc_top #(
   parameter int TICK    = smc_pkg::TICK_CYCLES,
   parameter int HOLDOFF = smc_pkg::HOLDOFF_TICKS
) (
   input  wire logic           clock,
   input  wire logic           nrst,
   input  wire smc_pkg::smc_bus_s bus,
   input  wire logic           digital_supply_ok,
   input  wire logic           analog_supply_ok,
   input  wire logic           irq_enable,
   output logic [7:0]          rdata,
   output logic                irq,
   output logic                watchdog_enable_clr,
   output smc_pkg::smc_trip_e  digital_trip,
   output smc_pkg::smc_trip_e  analog_trip,
   output logic                monitor_enable
);
   logic                  dok;
   logic                  aok;
   logic                  sel_ctrl;
   logic                  wr_ctrl;
   logic                  rd_ctrl;
   logic                  expire;
   logic                  low;
   logic                  flag_r;
   logic [15:0]           div_r;
   logic                  tick;
   logic [15:0]           hold_r;
   smc_pkg::smc_state_e   st_r;

   // -----------------------------------------------------------------
   // comparator conditioning
   // -----------------------------------------------------------------
   smc_filter u_fd (
      .clock (clock),
      .nrst  (nrst),
      .raw   (digital_supply_ok),
      .clean (dok)
   );
   smc_filter u_fa (
      .clock (clock),
      .nrst  (nrst),
      .raw   (analog_supply_ok),
      .clean (aok)
   );

   // -----------------------------------------------------------------
   // register decode
   // -----------------------------------------------------------------
   // strobes last one cycle; other addresses fall through untouched
   assign sel_ctrl = bus.addr == smc_pkg::SMC_CTRL_ADDR;
   assign wr_ctrl  = bus.wr && sel_ctrl;
   assign rd_ctrl  = bus.rd && sel_ctrl;

   // -----------------------------------------------------------------
   // low-supply condition
   // -----------------------------------------------------------------
   // a disabled monitor never reports a low supply, but the filters keep
   // running so that enabling during a dip reports it at once
   assign low      = monitor_enable && !(dok && aok);

   // -----------------------------------------------------------------
   // writable fields
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         monitor_enable <= smc_pkg::SMC_CTRL_RESET[smc_pkg::SMC_BIT_EN];
         digital_trip   <= smc_pkg::smc_trip_e'(smc_pkg::SMC_CTRL_RESET[
                              smc_pkg::SMC_BIT_DSEL_HI:
                              smc_pkg::SMC_BIT_DSEL_LO]);
         analog_trip    <= smc_pkg::smc_trip_e'(smc_pkg::SMC_CTRL_RESET[
                              smc_pkg::SMC_BIT_ASEL_HI:
                              smc_pkg::SMC_BIT_ASEL_LO]);
      end else if (wr_ctrl) begin
         monitor_enable <= bus.wdata[smc_pkg::SMC_BIT_EN];
         digital_trip   <= smc_pkg::smc_trip_e'(bus.wdata[
                              smc_pkg::SMC_BIT_DSEL_HI:
                              smc_pkg::SMC_BIT_DSEL_LO]);
         analog_trip    <= smc_pkg::smc_trip_e'(bus.wdata[
                              smc_pkg::SMC_BIT_ASEL_HI:
                              smc_pkg::SMC_BIT_ASEL_LO]);
      end
   end

   // -----------------------------------------------------------------
   // millisecond timebase
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_r <= 16'h0000;
      end else if (div_r == 16'(TICK - 1)) begin
         div_r <= 16'h0000;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end
   assign tick = div_r == 16'(TICK - 1);

   // the timebase runs free, so the first tick of a hold-off lands anywhere
   // in its first period; expiry falls between HOLDOFF-1 and HOLDOFF ticks
   assign expire = st_r == smc_pkg::SMC_ST_HOLDOFF && tick
                   && hold_r == 16'(HOLDOFF - 1);

   // -----------------------------------------------------------------
   // recovery state machine
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_r   <= smc_pkg::SMC_ST_OK;
         hold_r <= 16'h0000;
      end else begin
         case (st_r)
            smc_pkg::SMC_ST_OK: begin
               if (low) begin
                  st_r <= smc_pkg::SMC_ST_LOW;
               end
            end
            smc_pkg::SMC_ST_LOW: begin
               if (!low) begin
                  st_r   <= smc_pkg::SMC_ST_HOLDOFF;
                  hold_r <= 16'h0000;
               end
            end
            smc_pkg::SMC_ST_HOLDOFF: begin
               if (low) begin
                  st_r <= smc_pkg::SMC_ST_LOW;
               end else if (expire) begin
                  st_r <= smc_pkg::SMC_ST_OK;
               end else if (tick) begin
                  hold_r <= hold_r + 16'h0001;
               end
            end
            default: begin
               st_r <= smc_pkg::SMC_ST_OK;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // low-supply flag; hardware set wins over any software clear
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         flag_r <= smc_pkg::SMC_CTRL_RESET[smc_pkg::SMC_BIT_FLAG];
      end else if (low) begin
         flag_r <= 1'b1;
      end else if (expire) begin
         flag_r <= 1'b0;
      end else if (wr_ctrl) begin
         flag_r <= bus.wdata[smc_pkg::SMC_BIT_FLAG];
      end
   end

   // -----------------------------------------------------------------
   // interrupt, watchdog and read data
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= flag_r && irq_enable;
      end
   end

   // the watchdog clear follows the interrupt request itself, so a masked
   // flag leaves the watchdog running
   always_ff @(posedge clock) begin
      if (!nrst) begin
         watchdog_enable_clr <= 1'b0;
      end else begin
         watchdog_enable_clr <= flag_r && irq_enable;
      end
   end

   // the read image is built from the named bit positions, so a moved
   // field only needs the package changed
   function automatic logic [7:0] ctrl_byte(
      input logic               d_ok,
      input logic               a_ok,
      input logic               flag,
      input smc_pkg::smc_trip_e d_trip,
      input smc_pkg::smc_trip_e a_trip,
      input logic               en
   );
      logic [7:0] b;
      b = 8'h00;
      b[smc_pkg::SMC_BIT_DOK] = d_ok;
      b[smc_pkg::SMC_BIT_AOK] = a_ok;
      b[smc_pkg::SMC_BIT_FLAG] = flag;
      b[smc_pkg::SMC_BIT_DSEL_HI:smc_pkg::SMC_BIT_DSEL_LO] = d_trip;
      b[smc_pkg::SMC_BIT_ASEL_HI:smc_pkg::SMC_BIT_ASEL_LO] = a_trip;
      b[smc_pkg::SMC_BIT_EN] = en;
      return b;
   endfunction

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd_ctrl) begin
         rdata <= ctrl_byte(dok, aok, flag_r, digital_trip, analog_trip,
                            monitor_enable);
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// [tb_smc_top.sv]
// self-checking bench for the supply monitor control block
`timescale 1ns/10ps
module tb_smc_top;
   localparam int TICK = 8;
   localparam int HOLDOFF = 3;
   logic               clock = 0, nrst = 0, irq_enable = 0;
   smc_pkg::smc_bus_s  bus = '0;
   logic [12:0]        dv = 13'h1388, av = 13'h1388;
   logic [7:0]         r, v, wd;
   logic               irq, wdc, dok, aok, men;
   smc_pkg::smc_trip_e dtrip, atrip;
   int                 error_cnt = 0, checked = 0;
   smc_top #(.TICK(TICK), .HOLDOFF(HOLDOFF)) smc_top_i (.clock(clock),
      .nrst(nrst), .bus(bus), .digital_supply_ok(dok),
      .analog_supply_ok(aok), .irq_enable(irq_enable), .rdata(r),
      .irq(irq), .watchdog_enable_clr(wdc), .digital_trip(dtrip),
      .analog_trip(atrip), .monitor_enable(men));
   smc_supply_model smc_supply_model_i (.digital_trip(dtrip),
      .analog_trip(atrip), .dv_mv(dv), .av_mv(av),
      .digital_supply_ok(dok), .analog_supply_ok(aok));
   initial forever #12.5 clock = ~clock;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(logic [7:0] d);
      @(negedge clock) bus <= '{1'b1, 1'b0, 8'hDF, d};
      @(negedge clock) bus <= '0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge clock) bus <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clock) v = r;
      bus <= '0;
   endtask
   function automatic logic ok_exp(logic [1:0] c, logic [12:0] mv);
      logic [12:0] t [4] = '{13'h1216, 13'hC08, 13'hB72, 13'hA46};
      return mv > t[c];
   endfunction
   task automatic conclude;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #50000;
      error_cnt++;
      conclude();
   end
   initial begin
      v = 8'($urandom(75617));
      cyc(12);
      nrst = 1;
      rd(8'hDF);
      chk(v, smc_pkg::SMC_CTRL_RESET);
      repeat (6) begin
         wd = 8'($urandom) & 8'hDF;
         wr(wd);
         rd(8'hDF);
         chk(v, {3'b110, wd[4:0]});
         rd(8'($urandom_range(32'hDE, 32'h00)));
         chk(v, 8'h00);
      end
      dv = 13'hBB8;
      av = 13'hBB8;
      for (int c = 0; c < 4; c++) begin
         wr({3'b000, c[1:0], c[1:0], 1'b0});
         cyc(12);
         rd(8'hDF);
         wd = {ok_exp(c[1:0], dv), ok_exp(c[1:0], av), 1'b0, c[1:0],
               c[1:0], 1'b0};
         chk(v, wd);
      end
      dv = 13'h1388;
      av = 13'h1388;
      wr(8'h01);
      cyc(12);
      irq_enable = 1;
      wr(8'h21);
      rd(8'hDF);
      chk(v, 8'hE1);
      wr(8'h01);
      rd(8'hDF);
      chk(v, 8'hC1);
      dv = 13'h0000;
      cyc(5);
      dv = 13'h1388;
      cyc(20);
      rd(8'hDF);
      chk(v, 8'hC1);
      dv = 13'h0000;
      cyc(30);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, wdc}, 8'h01);
      wr(8'h01);
      rd(8'hDF);
      chk(v, 8'h61);
      irq_enable = 0;
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, wdc}, 8'h00);
      irq_enable = 1;
      dv = 13'h1388;
      cyc(12);
      dv = 13'h0000;
      cyc(20);
      dv = 13'h1388;
      cyc(20);
      rd(8'hDF);
      chk(v, 8'hE1);
      cyc(40);
      rd(8'hDF);
      chk(v, 8'hC1);
      chk({7'h00, irq}, 8'h00);
      av = 13'h0000;
      cyc(30);
      rd(8'hDF);
      chk(v, 8'hA1);
      av = 13'h1388;
      cyc(40);
      rd(8'hDF);
      chk(v, 8'hC1);
      nrst = 0;
      cyc(2);
      nrst = 1;
      rd(8'hDF);
      chk(v, smc_pkg::SMC_CTRL_RESET);
      conclude();
   end
endmodule
bind smc_top smc_chk #(.TICK(TICK), .HOLDOFF(HOLDOFF)) smc_chk_i (
   .clock(clock), .nrst(nrst), .bus(bus), .irq_enable(irq_enable),
   .digital_supply_ok(digital_supply_ok), .rdata(rdata), .irq(irq),
   .watchdog_enable_clr(watchdog_enable_clr), .digital_trip(digital_trip),
   .analog_trip(analog_trip), .monitor_enable(monitor_enable));
